// ---- rtl/gauge_i2c_command_port.sv ----
// Two-wire target port into the gauge command space.
// Operation
// RQ1 - Answer only target address 1010101, fixed.
// RQ2 - Host sends 0xAA to write, 0xAB read.
// RQ3 - Five transfer kinds: read, burst, quick, writes.
// RQ4 - Quick read returns byte at held pointer.
// RQ5 - Pointer advances on every acknowledged data byte.
// RQ6 - Multi-byte writes fill consecutive command locations.
// RQ7 - Read-only location write: NACK data, unchanged.
// RQ8 - Command address above 0x6B gets NACK.
// RQ9 - Bus low two seconds: release both drivers.
// RQ10 - Still held low afterwards: enter sleep.
// RQ11 - Above 100 kHz host uses single-byte writes.
// RQ12 - Host issues standard commands at most twice/second.
// RQ13 - Asleep: stretch clock while waking, 4 ms.
// RQ14 - Foreign addresses ignored, pointer left alone.
// RQ15 - Command byte of writes loads the pointer.
`timescale 1ns/10ps
module gauge_i2c_command_port #(
	parameter int TIMEOUT_CYCLES = gauge_pkg::TIMEOUT_CYC,
	parameter int WAKE_CYCLES    = gauge_pkg::WAKE_CYC
) (
	input  wire logic          i_ref_clk,
	input  wire logic          i_sys_rst,
	input  wire logic          i_core_clk,
	input  wire logic          i_core_rst,
	input  wire logic          i_scl_in,
	output logic               o_scl_out,
	output logic               o_scl_oe_n,
	input  wire logic          i_sda_in,
	output logic               o_sda_out,
	output logic               o_sda_oe_n,
	output logic               o_wr_valid,
	output gauge_pkg::cmd_wr_t o_wr,
	input  wire logic          i_wr_ready,
	output logic               o_asleep
);
	if (TIMEOUT_CYCLES < 64 || WAKE_CYCLES < 1) begin : g_bad
		$error("gauge port needs TIMEOUT >= 64 and WAKE >= 1");
	end

	localparam int SLEEP_AT = TIMEOUT_CYCLES + gauge_pkg::SETTLE_CYC;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_SKIP
	} port_state_t;

	// Command locations that can be addressed at all.
	function automatic logic cmd_ok(input logic [7:0] a);
		cmd_ok = (a <= gauge_pkg::CMD_MAX);
	endfunction

	// Locations that accept host data; the rest are read-only.
	function automatic logic cmd_writable(input logic [7:0] a);
		cmd_writable = (a >= gauge_pkg::WR_LO0 && a <= gauge_pkg::WR_HI0)
			|| (a >= gauge_pkg::WR_LO1 && a <= gauge_pkg::WR_HI1);
	endfunction

	port_state_t state_q, state_d;
	logic [2:0]  scl_sy_q;
	logic [2:0]  sda_sy_q;
	logic [3:0]  bits_q, bits_d;
	logic [7:0]  shift_q, shift_d;
	logic [7:0]  ptr_q, ptr_d;
	logic        rd_q, rd_d;
	logic        pend_q, pend_d;
	logic        hack_q, hack_d;
	logic        sda_low_q, sda_low_d;
	logic        scl_low_q;
	logic        sda_oe_n_q;
	logic        scl_oe_n_q;
	logic [31:0] tmo_q;
	logic [31:0] wake_q;
	logic        released_q;
	logic        asleep_q;
	logic [7:0]  mem_q [gauge_pkg::CMD_DEPTH];
	logic        mem_we;
	logic        buf_rdy;
	logic        buf_vld;
	logic        link_rdy;
	gauge_pkg::cmd_wr_t buf_word;
	gauge_pkg::cmd_wr_t new_word;

	// Pin synchronisers; only the second and third stages feed logic.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			scl_sy_q <= 3'h7;
			sda_sy_q <= 3'h7;
		end else begin
			scl_sy_q <= {scl_sy_q[1:0], i_scl_in};
			sda_sy_q <= {sda_sy_q[1:0], i_sda_in};
		end
	end

	// Bus events seen on the synchronised lines.
	logic scl_w, sda_w, scl_rise, scl_fall, start_w, stop_w, bus_low;
	assign scl_w    = scl_sy_q[1];
	assign sda_w    = sda_sy_q[1];
	assign scl_rise = scl_sy_q[1] & ~scl_sy_q[2];
	assign scl_fall = ~scl_sy_q[1] & scl_sy_q[2];
	assign start_w  = scl_sy_q[1] & scl_sy_q[2] & sda_sy_q[2] & ~sda_w;
	assign stop_w   = scl_sy_q[1] & scl_sy_q[2] & ~sda_sy_q[2] & sda_w;
	assign bus_low  = ~scl_w | ~sda_w;

	// Byte decode shared by the state logic and the checks.
	logic byte_done, addr_hit, wr_ok, tmo_hit;
	logic [7:0] rd_byte;
	assign byte_done = scl_fall & (bits_q == 4'(gauge_pkg::BYTE_BITS));
	assign addr_hit  = (shift_q[7:1] == gauge_pkg::TARGET_ADDR);  // RQ1
	assign wr_ok     = cmd_ok(ptr_q) & cmd_writable(ptr_q);
	assign rd_byte   = cmd_ok(ptr_q) ? mem_q[ptr_q[6:0]]
		: gauge_pkg::BYTE_RST;
	assign tmo_hit   = (tmo_q == 32'(TIMEOUT_CYCLES - 1));
	assign mem_we    = (state_q == ST_WDATA_ACK) & pend_q & wr_ok & buf_rdy;
	assign new_word  = '{addr: ptr_q, data: shift_q};

	// Transfer sequencing; a start or stop overrides any state.
	always_comb begin
		state_d   = state_q;
		bits_d    = bits_q;
		shift_d   = shift_q;
		ptr_d     = ptr_q;
		rd_d      = rd_q;
		pend_d    = pend_q;
		hack_d    = hack_q;
		sda_low_d = sda_low_q;
		case (state_q)
			ST_ADDR, ST_CMD, ST_WDATA: begin
				if (scl_rise) begin
					shift_d = {shift_q[6:0], sda_w};
					bits_d  = bits_q + 4'h1;
				end else if (byte_done) begin
					bits_d = 4'h0;
					if (state_q == ST_ADDR) begin
						sda_low_d = addr_hit;
						rd_d      = shift_q[0];
						state_d   = addr_hit ? ST_ADDR_ACK : ST_SKIP;  // RQ14
					end else if (state_q == ST_CMD) begin
						sda_low_d = cmd_ok(shift_q);  // RQ8
						state_d   = cmd_ok(shift_q) ? ST_CMD_ACK : ST_SKIP;
						if (cmd_ok(shift_q)) begin
							ptr_d = shift_q;  // RQ15
						end
					end else begin
						pend_d  = 1'b1;
						state_d = ST_WDATA_ACK;
					end
				end
			end
			ST_ADDR_ACK: begin
				if (scl_fall && rd_q) begin
					shift_d   = rd_byte;  // RQ4
					sda_low_d = ~rd_byte[7];
					state_d   = ST_RDATA;
				end else if (scl_fall) begin
					sda_low_d = 1'b0;
					state_d   = ST_CMD;
				end
			end
			ST_CMD_ACK: begin
				if (scl_fall) begin
					sda_low_d = 1'b0;
					state_d   = ST_WDATA;  // RQ3
				end
			end
			ST_WDATA_ACK: begin
				if (pend_q && !wr_ok) begin
					pend_d  = 1'b0;
					state_d = ST_SKIP;  // RQ7
				end else if (mem_we) begin
					pend_d    = 1'b0;
					sda_low_d = 1'b1;
					ptr_d     = ptr_q + 8'h01;  // RQ6
				end else if (scl_fall && !pend_q) begin
					sda_low_d = 1'b0;
					state_d   = ST_WDATA;
				end
			end
			ST_RDATA: begin
				if (scl_fall && bits_q == 4'h7) begin
					bits_d    = 4'h0;
					sda_low_d = 1'b0;
					state_d   = ST_RDATA_ACK;
				end else if (scl_fall) begin
					shift_d   = {shift_q[6:0], 1'b0};
					sda_low_d = ~shift_q[6];
					bits_d    = bits_q + 4'h1;
				end
			end
			ST_RDATA_ACK: begin
				if (scl_rise) begin
					hack_d = ~sda_w;
					if (!sda_w) begin
						ptr_d = ptr_q + 8'h01;  // RQ5
					end
				end else if (scl_fall && hack_q) begin
					shift_d   = rd_byte;  // RQ3
					sda_low_d = ~rd_byte[7];
					state_d   = ST_RDATA;
				end else if (scl_fall) begin
					state_d = ST_SKIP;
				end
			end
			ST_IDLE, ST_SKIP: begin
				sda_low_d = 1'b0;
			end
			default: begin
				sda_low_d = 1'b0;
				state_d   = ST_IDLE;
			end
		endcase
		if (start_w) begin
			state_d   = ST_ADDR;
			bits_d    = 4'h0;
			pend_d    = 1'b0;
			sda_low_d = 1'b0;
		end else if (stop_w || tmo_hit) begin
			state_d   = ST_IDLE;  // RQ9
			pend_d    = 1'b0;
			sda_low_d = 1'b0;
		end
	end

	// Engine registers; the pointer survives from one transfer to the next.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_q   <= ST_IDLE;
			bits_q    <= 4'h0;
			shift_q   <= gauge_pkg::BYTE_RST;
			ptr_q     <= gauge_pkg::PTR_RST;
			rd_q      <= 1'b0;
			pend_q    <= 1'b0;
			hack_q    <= 1'b0;
			sda_low_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			bits_q    <= bits_d;
			shift_q   <= shift_d;
			ptr_q     <= ptr_d;
			rd_q      <= rd_d;
			pend_q    <= pend_d;
			hack_q    <= hack_d;
			sda_low_q <= sda_low_d;
		end
	end

	// Command space storage, one flop byte per location.
	for (genvar i = 0; i < gauge_pkg::CMD_DEPTH; i++) begin : g_mem
		always_ff @(posedge i_ref_clk) begin
			if (i_sys_rst) begin
				mem_q[i] <= gauge_pkg::BYTE_RST;
			end else if (mem_we && ptr_q == 8'(i)) begin
				mem_q[i] <= shift_q;  // RQ6
			end
		end
	end

	// Stuck-bus watch: release first, and sleep if the bus stays low,
	// since then someone else is holding it and waiting only burns power.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			tmo_q      <= 32'h0;
			released_q <= 1'b0;
			asleep_q   <= 1'b0;
		end else begin
			if (!bus_low) begin
				tmo_q      <= 32'h0;
				released_q <= 1'b0;
			end else if (tmo_q != 32'(SLEEP_AT)) begin
				tmo_q <= tmo_q + 32'h1;
			end
			if (tmo_hit) begin
				released_q <= 1'b1;  // RQ9
			end
			if (released_q && bus_low && tmo_q == 32'(SLEEP_AT - 1)) begin
				asleep_q <= 1'b1;  // RQ10
			end else if (start_w) begin
				asleep_q <= 1'b0;
			end
		end
	end

	// Wake stretch: SCL is held low from the first fall until the
	// count runs out, so the host sees one bounded stretch.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || tmo_hit) begin
			wake_q <= 32'h0;
		end else if (asleep_q && start_w) begin
			wake_q <= 32'(WAKE_CYCLES);  // RQ13
		end else if (wake_q != 32'h0) begin
			wake_q <= wake_q - 32'h1;
		end
	end

	// SCL is also held while the write buffer is full, so no byte is lost.
	logic scl_low_d;
	assign scl_low_d = (!tmo_hit && !released_q) &&
		(((wake_q > 32'h1) && (scl_low_q || !scl_w)) ||
		((state_q == ST_WDATA_ACK) && pend_q && wr_ok && !buf_rdy));

	// Open-drain drivers; enable is low while the line is pulled.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			scl_low_q  <= 1'b0;
			sda_oe_n_q <= 1'b1;
			scl_oe_n_q <= 1'b1;
		end else begin
			scl_low_q  <= scl_low_d;
			sda_oe_n_q <= ~(sda_low_d & ~released_q);
			scl_oe_n_q <= ~scl_low_d;
		end
	end

	assign o_sda_out  = 1'b0;
	assign o_scl_out  = 1'b0;
	assign o_sda_oe_n = sda_oe_n_q;
	assign o_scl_oe_n = scl_oe_n_q;
	assign o_asleep   = asleep_q;

	gauge_pair_buf #(
		.WIDTH ($bits(gauge_pkg::cmd_wr_t)),
		.DEPTH (gauge_pkg::BUF_DEPTH)
	) u_buf (
		.i_clk       (i_ref_clk),
		.i_rst       (i_sys_rst),
		.i_in_valid  (mem_we),
		.o_in_ready  (buf_rdy),
		.i_in_data   (new_word),
		.o_out_valid (buf_vld),
		.i_out_ready (link_rdy),
		.o_out_data  (buf_word)
	);

	gauge_cmd_link u_link (
		.i_ref_clk  (i_ref_clk),
		.i_ref_rst  (i_sys_rst),
		.i_valid    (buf_vld),
		.o_ready    (link_rdy),
		.i_word     (buf_word),
		.i_core_clk (i_core_clk),
		.i_core_rst (i_core_rst),
		.o_valid    (o_wr_valid),
		.o_word     (o_wr),
		.i_ready    (i_wr_ready)
	);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	a_addr_ack: assert property (  // RQ1
		(state_q == ST_ADDR && byte_done && addr_hit && !start_w
		&& !stop_w && !tmo_hit && !released_q) |=> !o_sda_oe_n
	) else $error("own address not acknowledged");

	a_foreign_skip: assert property (  // RQ14
		(state_q == ST_SKIP) |=> $stable(ptr_q)
	) else $error("pointer moved during foreign transfer");

	a_cmd_nack: assert property (  // RQ8
		(state_q == ST_CMD && byte_done && !cmd_ok(shift_q) && !start_w)
		|=> o_sda_oe_n && state_q != ST_CMD_ACK
	) else $error("out of range command acknowledged");

	a_cmd_load: assert property (  // RQ15
		(state_q == ST_CMD && byte_done && cmd_ok(shift_q) && !start_w)
		|=> ptr_q == $past(shift_q)
	) else $error("command byte did not load pointer");

	a_ro_nack: assert property (  // RQ7
		(state_q == ST_WDATA_ACK && pend_q && !wr_ok && !start_w)
		|-> !mem_we ##1 (o_sda_oe_n [*2])
	) else $error("read-only location write acknowledged");

	a_wr_step: assert property (  // RQ6
		(mem_we && !start_w) |=> ptr_q == 8'($past(ptr_q) + 8'h01)
	) else $error("pointer did not step after stored byte");

	a_rd_step: assert property (  // RQ5
		(state_q == ST_RDATA_ACK && scl_rise && !sda_w && !start_w)
		|=> ptr_q == 8'($past(ptr_q) + 8'h01)
	) else $error("pointer did not step after host ack");

	a_quick_read: assert property (  // RQ4
		(state_q == ST_ADDR_ACK && rd_q && scl_fall && !start_w
		&& !stop_w && !tmo_hit) |=> shift_q == $past(rd_byte)
	) else $error("quick read did not load pointed byte");

	a_tmo_release: assert property (  // RQ9
		tmo_hit |=> o_sda_oe_n && o_scl_oe_n
	) else $error("drivers held after bus timeout");

	a_sleep_entry: assert property (  // RQ10
		(released_q && bus_low && tmo_q == 32'(SLEEP_AT - 1) && !start_w)
		|=> o_asleep
	) else $error("no sleep after outside bus hold");

	a_wake_stretch: assert property (  // RQ13
		(asleep_q && start_w && !tmo_hit) |=> wake_q == 32'(WAKE_CYCLES)
	) else $error("wake stretch not started");
endmodule

// ---- rtl/gauge_pkg.sv ----
// Shared constants and types for the gauge serial command port.
package gauge_pkg;
	// Fixed target address, compared against the top seven bits.
	localparam logic [6:0] TARGET_ADDR = 7'h55;
	// Highest command location that can be addressed.
	localparam logic [7:0] CMD_MAX     = 8'h6b;
	localparam int         CMD_DEPTH   = 108;
	// Writable windows of the command space; all else is read-only.
	localparam logic [7:0] WR_LO0      = 8'h00;
	localparam logic [7:0] WR_HI0      = 8'h01;
	localparam logic [7:0] WR_LO1      = 8'h3e;
	localparam logic [7:0] WR_HI1      = 8'h61;
	// Reset values of the engine registers.
	localparam logic [7:0] PTR_RST     = 8'h00;
	localparam logic [7:0] BYTE_RST    = 8'h00;
	// Reference clock and derived timing counts.
	localparam int REF_CLK_HZ  = 20_000_000;
	localparam int TIMEOUT_MS  = 2000;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * (REF_CLK_HZ / 1000);
	localparam int WAKE_US     = 4000;
	localparam int WAKE_CYC    = WAKE_US * (REF_CLK_HZ / 1_000_000);
	// Cycles after release before an outside hold counts as stuck.
	localparam int SETTLE_CYC  = 8;
	localparam int BYTE_BITS   = 8;
	localparam int BUF_DEPTH   = 2;

	// One accepted write, passed on to the gauge core.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} cmd_wr_t;
endpackage

// ---- rtl/gauge_pair_buf.sv ----
// Small ring buffer with valid and ready on both sides.
`timescale 1ns/10ps
module gauge_pair_buf #(
	parameter int WIDTH = 16,
	parameter int DEPTH = gauge_pkg::BUF_DEPTH
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad
		$error("gauge_pair_buf needs DEPTH >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] slot_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic             push;
	logic             pop;

	// Full and empty follow the occupancy count directly.
	assign o_in_ready  = (cnt_q != CW'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = slot_q[rd_q];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Pointers wrap at DEPTH so any depth works, not just powers of two.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				slot_q[wr_q] <= i_in_data;
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end
endmodule

// ---- rtl/gauge_cmd_link.sv ----
// Handshake crossing of accepted writes into the gauge core clock.
`timescale 1ns/10ps
module gauge_cmd_link (
	input  wire logic      i_ref_clk,
	input  wire logic      i_ref_rst,
	input  wire logic      i_valid,
	output logic           o_ready,
	input  gauge_pkg::cmd_wr_t i_word,
	input  wire logic      i_core_clk,
	input  wire logic      i_core_rst,
	output logic           o_valid,
	output gauge_pkg::cmd_wr_t o_word,
	input  wire logic      i_ready
);
	gauge_pkg::cmd_wr_t hold_q;
	logic               req_q;
	logic [1:0]         ack_sy_q;
	logic [2:0]         req_sy_q;
	logic               ack_q;
	logic               valid_q;
	gauge_pkg::cmd_wr_t word_q;
	logic               take;
	logic               fresh;

	// The held word only changes while no request is outstanding.
	assign o_ready = (req_q == ack_sy_q[1]);
	assign take    = i_valid & o_ready;
	always_ff @(posedge i_ref_clk) begin
		if (i_ref_rst) begin
			hold_q   <= '0;
			req_q    <= 1'b0;
			ack_sy_q <= 2'h0;
		end else begin
			ack_sy_q <= {ack_sy_q[0], ack_q};
			if (take) begin
				hold_q <= i_word;
				req_q  <= ~req_q;
			end
		end
	end

	// Core side: a toggle seen past two flops marks a settled word.
	assign fresh   = req_sy_q[2] ^ req_sy_q[1];
	assign o_valid = valid_q;
	assign o_word  = word_q;
	always_ff @(posedge i_core_clk) begin
		if (i_core_rst) begin
			req_sy_q <= 3'h0;
			ack_q    <= 1'b0;
			valid_q  <= 1'b0;
			word_q   <= '0;
		end else begin
			req_sy_q <= {req_sy_q[1:0], req_q};
			if (fresh) begin
				valid_q <= 1'b1;
				word_q  <= hold_q;
			end else if (valid_q && i_ready) begin
				valid_q <= 1'b0;
				ack_q   <= ~ack_q;
			end
		end
	end
endmodule

// ---- test/gauge_host_model.sv ----
// Two-wire bus controller model that works the gauge port from the host side.
`timescale 1ns/10ps
module gauge_host_model (
	input  wire logic i_clk,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl_oe_n,
	output logic      o_sda_oe_n
);
	int half = 20;
	int stretch_max = 0;

	// Both lines start released so the pull-ups hold the bus idle.
	initial begin
		o_scl_oe_n = 1'b1;
		o_sda_oe_n = 1'b1;
	end

	// Release SCL and wait, bounded, while the target stretches it low.
	task automatic rise();
		int w;
		w = 0;
		o_scl_oe_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		while (i_scl !== 1'b1 && w < 3000) begin
			@(posedge i_clk);
			w++;
		end
		if (w > stretch_max) stretch_max = w;
		repeat (half) @(posedge i_clk);
	endtask

	// Data moves a few cycles after SCL falls, so no false start is seen.
	task automatic bit_xfer(input logic b, output logic r);
		repeat (4) @(posedge i_clk);
		o_sda_oe_n <= b;
		repeat (half) @(posedge i_clk);
		rise();
		r = i_sda;
		o_scl_oe_n <= 1'b0;
	endtask

	// Start from idle, or repeated start from the low clock phase.
	task automatic start();
		repeat (4) @(posedge i_clk);
		o_sda_oe_n <= 1'b1;
		repeat (half) @(posedge i_clk);
		rise();
		o_sda_oe_n <= 1'b0;
		repeat (half) @(posedge i_clk);
		o_scl_oe_n <= 1'b0;
	endtask

	// Stop leaves both lines released.
	task automatic stop();
		repeat (4) @(posedge i_clk);
		o_sda_oe_n <= 1'b0;
		repeat (half) @(posedge i_clk);
		rise();
		o_sda_oe_n <= 1'b1;
		repeat (half) @(posedge i_clk);
	endtask

	// A byte goes out MSB first; the ninth bit returns the target's answer.
	task automatic put_byte(input logic [7:0] b, output logic nack);
		for (int i = 7; i >= 0; i--) bit_xfer(b[i], nack);
		bit_xfer(1'b1, nack);
	endtask

	// A byte comes in MSB first; the host answers on the ninth bit.
	task automatic get_byte(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
		bit_xfer(nack, r);
	endtask
endmodule

// ---- test/gauge_i2c_command_port_bench.sv ----
// Self-checking bench for the gauge serial command port.
`timescale 1ns/10ps
module gauge_i2c_command_port_bench;
	localparam int TO_CYC = 4000;
	localparam int WK_CYC = 200;
	logic               ref_clk = 1'b0;
	logic               core_clk = 1'b0;
	logic               sys_rst = 1'b1;
	logic               core_rst = 1'b1;
	logic               wr_ready = 1'b0;
	logic               stall = 1'b0;
	logic               h_scl_oe_n, h_sda_oe_n, d_scl_oe_n, d_sda_oe_n;
	logic               wr_valid, asleep;
	logic               d_scl_out, d_sda_out;
	gauge_pkg::cmd_wr_t wr_word;
	gauge_pkg::cmd_wr_t exp_q[$];
	logic [7:0]         mem [256];
	logic [7:0]         ptr;
	logic [31:0]        seed = 32'h0000605e;
	logic [31:0]        core_seed = 32'h0000605e;
	int                 mismatches = 0;
	int                 comparisons = 0;
	int                 cycles = 0;
	// Open-drain wires: low when either side pulls, else pulled up.
	wire                scl = h_scl_oe_n & (d_scl_oe_n | d_scl_out);
	wire                sda = h_sda_oe_n & (d_sda_oe_n | d_sda_out);

	// The link clock starts off phase with the reference clock.
	initial forever #25 ref_clk = ~ref_clk;
	initial begin
		#3;
		forever #6 core_clk = ~core_clk;
	end

	gauge_i2c_command_port #(.TIMEOUT_CYCLES(TO_CYC), .WAKE_CYCLES(WK_CYC))
	i_dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_core_clk(core_clk),
		.i_core_rst(core_rst), .i_scl_in(scl), .o_scl_out(d_scl_out),
		.o_scl_oe_n(d_scl_oe_n), .i_sda_in(sda), .o_sda_out(d_sda_out),
		.o_sda_oe_n(d_sda_oe_n), .o_wr_valid(wr_valid), .o_wr(wr_word),
		.i_wr_ready(wr_ready), .o_asleep(asleep));
	gauge_host_model i_host (.i_clk(ref_clk), .i_scl(scl), .i_sda(sda),
		.o_scl_oe_n(h_scl_oe_n), .o_sda_oe_n(h_sda_oe_n));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function logic [7:0] rnd();
		seed = xs(seed);
		return seed[7:0];
	endfunction
	function automatic logic wr_ok(input logic [7:0] a);
		return (a >= gauge_pkg::WR_LO0 && a <= gauge_pkg::WR_HI0) ||
			(a >= gauge_pkg::WR_LO1 && a <= gauge_pkg::WR_HI1);
	endfunction

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic check_word(input gauge_pkg::cmd_wr_t got,
		input gauge_pkg::cmd_wr_t exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t core word got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Core side takes words at random, and never while a stall is set.
	always @(posedge core_clk) begin
		core_seed <= xs(core_seed);
		wr_ready <= !stall && core_seed[1:0] != 2'h0;
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			check_word(wr_word, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
		end
	end

	// A hang is cut short well past the expected run length.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 100000) begin
			mismatches++;
			$display("[FAIL] %0t run did not finish", $time);
			print_verdict();
		end
	end

	// Writes predict stores; an unwritable location ends the packet early.
	task automatic do_write(input logic [7:0] cmd, input int n);
		logic nk, ok;
		logic [7:0] d;
		i_host.start();
		i_host.put_byte(8'haa, nk);
		check_byte({7'h00, nk}, 8'h00, "addr ack");
		i_host.put_byte(cmd, nk);
		check_byte({7'h00, nk}, {7'h00, cmd > gauge_pkg::CMD_MAX}, "cmd");
		if (cmd <= gauge_pkg::CMD_MAX) ptr = cmd;
		for (int i = 0; i < n && cmd <= gauge_pkg::CMD_MAX; i++) begin
			d = rnd() | 8'h01;
			ok = wr_ok(ptr);
			if (ok) begin
				mem[ptr] = d;
				exp_q.push_back({ptr, d});
			end
			i_host.put_byte(d, nk);
			check_byte({7'h00, nk}, {7'h00, !ok}, "data ack");
			if (!ok) break;
			ptr++;
		end
		i_host.stop();
	endtask

	// A standard read loads the pointer first; a quick read uses the held one.
	task automatic do_read(input logic quick, input logic [7:0] cmd,
		input int n);
		logic nk;
		logic [7:0] d;
		i_host.start();
		if (!quick) begin
			i_host.put_byte(8'haa, nk);
			i_host.put_byte(cmd, nk);
			check_byte({7'h00, nk}, {7'h00, cmd > gauge_pkg::CMD_MAX}, "cmd");
			if (cmd > gauge_pkg::CMD_MAX) begin
				i_host.stop();
				return;
			end
			ptr = cmd;
			i_host.start();
		end
		i_host.put_byte(8'hab, nk);
		check_byte({7'h00, nk}, 8'h00, "read addr ack");
		for (int i = 1; i <= n; i++) begin
			i_host.get_byte(i == n, d);
			check_byte(d, (ptr <= gauge_pkg::CMD_MAX) ? mem[ptr] : 8'h00, "rd");
			if (i < n) ptr++;
		end
		i_host.stop();
	endtask

	// Main sequence: directed corners first, then random traffic, then sleep.
	initial begin
		logic nk, wk;
		logic [7:0] a;
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		core_rst <= 1'b0;
		repeat (6) @(posedge ref_clk);
		ptr = gauge_pkg::PTR_RST;
		do_read(1'b1, 8'h00, 2);
		$display("test reset_quick_read done");
		i_host.half = 100;
		stall <= 1'b1;
		fork
			do_write(8'h3e, 4);
			begin
				for (int w = 0; w < 20000 && d_scl_oe_n !== 1'b0; w++)
					@(posedge ref_clk);
				repeat (300) @(posedge ref_clk);
				stall <= 1'b0;
			end
		join
		check_byte({7'h00, i_host.stretch_max > 200}, 8'h01, "stall");
		do_write(8'h61, 2);
		i_host.half = 20;
		$display("test burst_write done");
		do_read(1'b0, 8'h3e, 4);
		do_read(1'b1, 8'h00, 2);
		do_read(1'b0, 8'h60, 3);
		do_write(8'h02, 1);
		do_read(1'b0, 8'h02, 1);
		$display("test read_back done");
		do_read(1'b0, 8'h6b, 1);
		do_read(1'b0, 8'h6c, 1);
		do_read(1'b0, 8'hff, 1);
		do_write(8'h6c, 1);
		$display("test range done");
		// Park the pointer on a stored non-zero byte so a stray step shows.
		do_read(1'b0, 8'h3e, 1);
		for (int k = 0; k < 3; k++) begin
			a = rnd();
			if (a[7:1] == gauge_pkg::TARGET_ADDR) a = a ^ 8'h02;
			i_host.start();
			i_host.put_byte(a, nk);
			check_byte({7'h00, nk}, 8'h01, "foreign");
			i_host.stop();
		end
		do_read(1'b1, 8'h00, 1);
		$display("test foreign done");
		// The port has no watchdog, so back-to-back commands are legal here.
		for (int k = 0; k < 8; k++) begin
			a = rnd() % 8'h6c;
			do_write(a, 1);
			do_read(1'b0, a, 1);
		end
		$display("test random done");
		a = 8'haa;
		i_host.start();
		for (int i = 7; i >= 0; i--) i_host.bit_xfer(a[i], nk);
		repeat (4) @(posedge ref_clk);
		i_host.o_sda_oe_n <= 1'b1;
		repeat (TO_CYC / 2) @(posedge ref_clk);
		check_byte({7'h00, d_sda_oe_n}, 8'h00, "ack held");
		repeat (TO_CYC / 2 + 20) @(posedge ref_clk);
		check_byte({6'h00, d_scl_oe_n, d_sda_oe_n}, 8'h03, "release");
		repeat (20) @(posedge ref_clk);
		check_byte({7'h00, asleep}, 8'h01, "asleep");
		i_host.o_scl_oe_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		i_host.stretch_max = 0;
		do_read(1'b1, 8'h00, 1);
		// The wake count starts at the start, so the host's own low phase
		// before it lets go of SCL is taken out of the stretch it sees.
		wk = i_host.stretch_max inside {[WK_CYC - 60 : WK_CYC]};
		check_byte({7'h00, wk}, 8'h01, "wake");
		check_byte({7'h00, asleep}, 8'h00, "awake");
		$display("test timeout_sleep done");
		for (int w = 0; w < 2000 && exp_q.size() > 0; w++) @(posedge ref_clk);
		check_byte(8'(exp_q.size()), 8'h00, "words left");
		print_verdict();
	end
endmodule
